// ### logic/hbu_top.sv
// Host buffered serial port: byte transfers from the host to and from a serial line.
// Assumes host commands are one-cycle pulses synchronous to i_clk and pins are already synchronous.
//
// What this block does
// - Transmit line sits just after enabled timers and counters; receive line next.
// - Every character is eight data bits, no parity, one stop bit.
// - Lines are non-inverted: idle and stop high, start low.
// - Received characters are stored only after the buffering enable command.
// - A receive request reports buffer fill as it stood before the read.
// - A receive request returns at most 32 bytes; the rest stay queued in order.
// - A transmit request sends 0 to 56 bytes and replies with the buffer fill.
// - The discard command empties the receive buffer; its value is ignored.
// - Wide factor equals 2^16 minus 48 MHz over twice the bit rate.
// - Narrow variant uses an 8-bit factor: 2^8 minus base over bit rate.
`timescale 1ns/100ps
module hbu_top (
  // Clock and reset.
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Configuration.
  input  wire hbu_pkg::hbu_rate_s     i_rate,
  input  wire hbu_pkg::hbu_place_s    i_place,
  // Buffering commands.
  input  wire logic                   i_rx_buffering_enable,
  input  wire logic                   i_enable_value,
  input  wire logic                   i_rx_buffer_discard,
  // Transmit request and its bytes.
  input  wire logic                   i_transmit_request,
  input  wire logic [5:0]             i_tx_count,
  input  wire logic [7:0]             i_tx_data,
  input  wire logic                   i_tx_valid,
  output logic                        o_tx_ready,
  output logic                        o_tx_reply_valid,
  // Receive request and its bytes.
  input  wire logic                   i_receive_request,
  output logic                        o_rx_reply_valid,
  output logic [7:0]                  o_rx_data,
  output logic                        o_rx_data_valid,
  output logic                        o_rx_done,
  // Status.
  output logic [6:0]                  o_rx_fill,
  output logic                        o_rx_enabled,
  // Flexible digital lines.
  input  wire logic [7:0]             i_fdl_in,
  output logic [7:0]                  o_fdl_out,
  output logic [7:0]                  o_fdl_oe_n
);

  // Base rate enable: a phase accumulator spreads 48 enables over every 200 clocks.
  logic [7:0] acc_r;
  logic       base_en_r;
  wire  [8:0] acc_sum  = {1'b0, acc_r} + {1'b0, hbu_pkg::ACC_STEP};
  wire        acc_wrap = acc_sum >= {1'b0, hbu_pkg::ACC_WRAP};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_r     <= 8'h00;
      base_en_r <= 1'b0;
    end else begin
      acc_r     <= acc_wrap ? 8'(acc_sum - {1'b0, hbu_pkg::ACC_WRAP}) : acc_sum[7:0];
      base_en_r <= acc_wrap;
    end
  end

  // Pin placement; a line placed beyond the last pin is simply not connected.
  wire [4:0] tx_idx = 5'(i_place.pin_offset) + 5'(i_place.timers) + 5'(i_place.counters);
  wire [4:0] rx_idx = tx_idx + 5'h01;
  wire       rx_line = (rx_idx <= hbu_pkg::FDL_LAST) ? i_fdl_in[rx_idx[2:0]] : hbu_pkg::IDLE_LEVEL;

  // Bit timers, one per direction so the receiver can align to each start edge.
  logic tx_restart;
  logic rx_restart;
  logic tx_tick;
  logic rx_tick;

  hbu_bit_timer u_tx_timer (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_base_en (base_en_r),
    .i_restart (tx_restart),
    .i_half    (1'b0),
    .i_rate    (i_rate),
    .o_tick    (tx_tick)
  );

  hbu_bit_timer u_rx_timer (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_base_en (base_en_r),
    .i_restart (rx_restart),
    .i_half    (1'b1),
    .i_rate    (i_rate),
    .o_tick    (rx_tick)
  );

  // Receive store with fill count; the array holds bytes in arrival order.
  logic [7:0]              rx_mem [hbu_pkg::RX_DEPTH];
  logic [hbu_pkg::RX_AW-1:0] wr_ptr_r;
  logic [hbu_pkg::RX_AW-1:0] rd_ptr_r;
  logic [6:0]              fill_r;
  logic                    rx_en_r;
  logic                    push;
  logic [7:0]              push_data;
  logic                    pop;

  wire       can_push = push && rx_en_r && (fill_r != hbu_pkg::RX_FULL);
  wire [6:0] fill_nxt = i_rx_buffer_discard ? {6'h00, can_push} :
                        fill_r + {6'h00, can_push} - {6'h00, pop};

  // Enable register: later commands may switch storing off again.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_en_r <= hbu_pkg::RX_EN_RST;
    end else if (i_rx_buffering_enable) begin
      rx_en_r <= i_enable_value;
    end
  end

  // A byte arriving in the discard cycle survives, so discard never eats fresh data.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fill_r   <= 7'h00;
    end else begin
      fill_r <= fill_nxt;
      if (i_rx_buffer_discard) begin
        rd_ptr_r <= wr_ptr_r;
      end else if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (can_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
    end
  end

  // Storage array without reset.
  always_ff @(posedge i_clk) begin
    if (can_push) begin
      rx_mem[wr_ptr_r] <= push_data;
    end
  end

  // Host read: report the fill before the read, then stream up to 32 bytes.
  logic       reading_r;
  logic [6:0] read_left_r;
  logic       rx_reply_r;
  logic [7:0] rx_data_r;
  logic       rx_dv_r;
  logic       rx_done_r;
  logic [6:0] fill_out_r;
  logic       tx_reply_r;

  wire start_read = i_receive_request && !reading_r;
  wire read_end   = reading_r && ((read_left_r == 7'h00) || (fill_r == 7'h00));
  assign pop      = reading_r && !read_end && !i_rx_buffer_discard;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reading_r   <= 1'b0;
      read_left_r <= 7'h00;
      rx_reply_r  <= 1'b0;
      rx_data_r   <= 8'h00;
      rx_dv_r     <= 1'b0;
      rx_done_r   <= 1'b0;
    end else begin
      rx_reply_r <= start_read;
      rx_dv_r    <= pop;
      rx_done_r  <= read_end;
      if (pop) begin
        rx_data_r   <= rx_mem[rd_ptr_r];
        read_left_r <= read_left_r - 7'h01;
      end
      if (start_read) begin
        reading_r   <= 1'b1;
        read_left_r <= (fill_r > hbu_pkg::RX_READ_MAX) ? hbu_pkg::RX_READ_MAX : fill_r;
      end else if (read_end) begin
        reading_r <= 1'b0;
      end
    end
  end

  // Fill report: frozen at a receive request so its reply shows the count before the read; the transmit reply shows the live count.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fill_out_r <= 7'h00;
    end else if (start_read) begin
      fill_out_r <= fill_r;
    end else if (!reading_r) begin
      fill_out_r <= fill_r;
    end
  end

  // Transmitter: fetch a byte from the host, shift out ten bits, repeat for the count.
  hbu_pkg::hbu_tx_state_e tx_state_r;
  logic [9:0]             tx_frame_r;
  logic [3:0]             tx_bits_r;
  logic [5:0]             tx_left_r;
  logic                   tx_phase_r;
  logic                   tx_ready_r;
  logic                   tx_line_r;

  wire tx_take    = (tx_state_r == hbu_pkg::TX_FETCH) && tx_ready_r && i_tx_valid;
  wire tx_bit_evt = tx_tick && (i_rate.narrow || tx_phase_r);
  wire tx_cmd_ok  = i_transmit_request && (tx_state_r == hbu_pkg::TX_IDLE);
  assign tx_restart = tx_take;

  // Counts above the limit are refused: the reply comes at once and nothing is sent.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_state_r <= hbu_pkg::TX_IDLE;
      tx_frame_r <= {10{hbu_pkg::IDLE_LEVEL}};
      tx_bits_r  <= 4'h0;
      tx_left_r  <= 6'h00;
      tx_phase_r <= 1'b0;
      tx_ready_r <= 1'b0;
      tx_reply_r <= 1'b0;
    end else begin
      tx_reply_r <= 1'b0;
      if (tx_tick) begin
        tx_phase_r <= i_rate.narrow ? 1'b0 : !tx_phase_r;
      end
      unique case (tx_state_r)
        hbu_pkg::TX_IDLE: begin
          if (tx_cmd_ok && (i_tx_count != 6'h00) && (i_tx_count <= hbu_pkg::TX_MAX)) begin
            tx_left_r  <= i_tx_count;
            tx_ready_r <= 1'b1;
            tx_state_r <= hbu_pkg::TX_FETCH;
          end else if (tx_cmd_ok) begin
            tx_reply_r <= 1'b1;
          end
        end
        hbu_pkg::TX_FETCH: begin
          if (tx_take) begin
            tx_frame_r <= {hbu_pkg::IDLE_LEVEL, i_tx_data, hbu_pkg::START_LEVEL};
            tx_bits_r  <= 4'h0;
            tx_phase_r <= 1'b0;
            tx_ready_r <= 1'b0;
            tx_left_r  <= tx_left_r - 6'h01;
            tx_state_r <= hbu_pkg::TX_SHIFT;
          end
        end
        hbu_pkg::TX_SHIFT: begin
          if (tx_bit_evt) begin
            tx_frame_r <= {hbu_pkg::IDLE_LEVEL, tx_frame_r[9:1]};
            tx_bits_r  <= tx_bits_r + 4'h1;
            if (tx_bits_r == hbu_pkg::FRAME_BITS - 4'h1) begin
              tx_ready_r <= (tx_left_r != 6'h00);
              tx_reply_r <= (tx_left_r == 6'h00);
              tx_state_r <= (tx_left_r != 6'h00) ? hbu_pkg::TX_FETCH : hbu_pkg::TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_r <= hbu_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Receiver: align on the start edge, sample each bit mid-way, check the stop bit.
  hbu_pkg::hbu_rx_state_e rx_state_r;
  logic [7:0]             rx_shift_r;
  logic [3:0]             rx_bits_r;
  logic                   rx_phase_r;

  wire rx_bit_evt = rx_tick && (i_rate.narrow || rx_phase_r);
  assign rx_restart = (rx_state_r == hbu_pkg::RX_IDLE) && (rx_line == hbu_pkg::START_LEVEL);
  // The bit count still at eight marks a stop bit that was high at its own sample point.
  assign push       = (rx_state_r == hbu_pkg::RX_STOP) && rx_bit_evt && (rx_line == hbu_pkg::IDLE_LEVEL) &&
                      rx_bits_r[3];
  assign push_data  = rx_shift_r;

  // A low stop bit is a framing error: the byte is dropped and the line must go idle first.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_state_r <= hbu_pkg::RX_IDLE;
      rx_shift_r <= 8'h00;
      rx_bits_r  <= 4'h0;
      rx_phase_r <= 1'b0;
    end else begin
      if (rx_restart) begin
        rx_phase_r <= 1'b1;
      end else if (rx_tick) begin
        rx_phase_r <= i_rate.narrow ? 1'b0 : !rx_phase_r;
      end
      unique case (rx_state_r)
        hbu_pkg::RX_IDLE: begin
          if (rx_restart) begin
            rx_state_r <= hbu_pkg::RX_START;
          end
        end
        hbu_pkg::RX_START: begin
          if (rx_bit_evt) begin
            rx_bits_r  <= 4'h0;
            rx_state_r <= (rx_line == hbu_pkg::START_LEVEL) ? hbu_pkg::RX_DATA : hbu_pkg::RX_IDLE;
          end
        end
        hbu_pkg::RX_DATA: begin
          if (rx_bit_evt) begin
            rx_shift_r <= {rx_line, rx_shift_r[7:1]};
            rx_bits_r  <= rx_bits_r + 4'h1;
            if (rx_bits_r == hbu_pkg::LAST_DATA) begin
              rx_state_r <= hbu_pkg::RX_STOP;
            end
          end
        end
        hbu_pkg::RX_STOP: begin
          if (rx_bit_evt && (rx_line == hbu_pkg::IDLE_LEVEL)) begin
            rx_state_r <= hbu_pkg::RX_IDLE;
          end else if (rx_bit_evt) begin
            rx_bits_r <= 4'h0;
          end
        end
      endcase
    end
  end

  // Pin drivers: only the transmit line is driven, idle high.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_line_r  <= hbu_pkg::IDLE_LEVEL;
      o_fdl_out  <= 8'hFF;
      o_fdl_oe_n <= 8'hFF;
    end else begin
      tx_line_r <= (tx_state_r == hbu_pkg::TX_SHIFT) ? tx_frame_r[0] : hbu_pkg::IDLE_LEVEL;
      for (int i = 0; i < hbu_pkg::FDL_COUNT; i++) begin
        o_fdl_out[i]  <= (tx_idx == 5'(i)) ? tx_line_r : hbu_pkg::IDLE_LEVEL;
        o_fdl_oe_n[i] <= (tx_idx != 5'(i));
      end
    end
  end

  assign o_tx_ready       = tx_ready_r;
  assign o_tx_reply_valid = tx_reply_r;
  assign o_rx_reply_valid = rx_reply_r;
  assign o_rx_data        = rx_data_r;
  assign o_rx_data_valid  = rx_dv_r;
  assign o_rx_done        = rx_done_r;
  assign o_rx_fill        = fill_out_r;
  assign o_rx_enabled     = rx_en_r;

endmodule : hbu_top

// ### logic/hbu_pkg.sv
// Shared constants, states and carriers of the host buffered serial port.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
package hbu_pkg;

  // Clock rates in MHz; the 48 MHz base is made as an enable from the system clock.
  localparam int unsigned SYS_CLK_MHZ  = 200;
  localparam int unsigned BASE_CLK_MHZ = 48;
  localparam logic [7:0]  ACC_STEP     = 8'(BASE_CLK_MHZ);
  localparam logic [7:0]  ACC_WRAP     = 8'(SYS_CLK_MHZ);

  // Divider limits: the counter overflows at these values and reloads with the factor.
  localparam logic [15:0] WIDE_LIMIT   = 16'hFFFF;
  localparam logic [15:0] NARROW_LIMIT = 16'h00FF;

  // Character framing: start, eight data bits, no parity, one stop.
  localparam int unsigned DATA_BITS    = 8;
  localparam logic [3:0]  FRAME_BITS   = 4'hA;
  localparam logic [3:0]  LAST_DATA    = 4'h7;
  localparam logic        IDLE_LEVEL   = 1'b1;
  localparam logic        START_LEVEL  = 1'b0;

  // Transfer limits and receive store size.
  localparam logic [5:0]  TX_MAX       = 6'h38;
  localparam logic [6:0]  RX_READ_MAX  = 7'h20;
  localparam int unsigned RX_DEPTH     = 64;
  localparam int unsigned RX_AW        = 6;
  localparam logic [6:0]  RX_FULL      = 7'h40;

  // Flexible digital lines and pin placement.
  localparam int unsigned FDL_COUNT    = 8;
  localparam logic [4:0]  FDL_LAST     = 5'h07;

  // Reset values.
  localparam logic        RX_EN_RST    = 1'b0;
  localparam logic [15:0] FACTOR_RST   = 16'h0000;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_FETCH = 2'b01,
    TX_SHIFT = 2'b10
  } hbu_tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } hbu_rx_state_e;

  // Bit rate setting.
  typedef struct packed {
    logic        narrow;
    logic [15:0] factor;
  } hbu_rate_s;

  // Pin placement setting.
  typedef struct packed {
    logic [3:0] pin_offset;
    logic [1:0] timers;
    logic [1:0] counters;
  } hbu_place_s;

endpackage : hbu_pkg

// ### logic/hbu_bit_timer.sv
// Reloading up-counter that marks serial bit timing off the 48 MHz base enable.
// Assumes i_base_en is a one-cycle pulse at the base rate and the factor is held steady.
`timescale 1ns/100ps
module hbu_bit_timer (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Timing control.
  input  wire logic        i_base_en,
  input  wire logic        i_restart,
  input  wire logic        i_half,
  input  wire hbu_pkg::hbu_rate_s i_rate,
  // Overflow pulse.
  output logic             o_tick
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        tick_r;
  wire  [15:0] limit    = i_rate.narrow ? hbu_pkg::NARROW_LIMIT : hbu_pkg::WIDE_LIMIT;
  wire  [15:0] fac      = i_rate.narrow ? {8'h00, i_rate.factor[7:0]} : i_rate.factor;
  wire  [15:0] half_pre = fac + ((limit - fac) >> 1);
  wire         ovf      = i_base_en && (cnt_r == limit);

  // A restart aligns the count to a line edge; in narrow mode a half preload lets the caller sample mid-bit.
  assign cnt_nxt = i_restart ? ((i_half && i_rate.narrow) ? half_pre : fac) :
                   ovf       ? fac :
                   i_base_en ? cnt_r + 16'h0001 : cnt_r;

  // Counter and its overflow pulse.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= ovf && !i_restart;
    end
  end

  assign o_tick = tick_r;

endmodule : hbu_bit_timer

// ### dv/hbu_top_props.sv
// Checker for the buffered serial port, bound to the top module's ports.
// Assumes one clock and that no discard lands inside a read.
`timescale 1ns/100ps
module hbu_top_props (
  // Clock and reset.
  input wire logic                i_clk,
  input wire logic                i_rst,
  // Watched ports.
  input wire hbu_pkg::hbu_place_s i_place,
  input wire logic                i_rx_buffering_enable,
  input wire logic                i_enable_value,
  input wire logic                i_rx_buffer_discard,
  input wire logic                i_transmit_request,
  input wire logic [5:0]          i_tx_count,
  input wire logic                o_tx_ready,
  input wire logic                o_tx_reply_valid,
  input wire logic                i_receive_request,
  input wire logic                o_rx_reply_valid,
  input wire logic                o_rx_data_valid,
  input wire logic                o_rx_done,
  input wire logic [6:0]          o_rx_fill,
  input wire logic                o_rx_enabled,
  input wire logic [7:0]          o_fdl_out,
  input wire logic [7:0]          o_fdl_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic                tx_busy_r;
  logic                rd_on_r;
  logic [1:0]          pl_age_r;
  logic [6:0]          dv_cnt_r;
  logic [6:0]          fill_cap_r;
  hbu_pkg::hbu_place_s place_q_r;

  // Expected pin positions and read length, worked out from the inputs.
  wire [4:0] tx_idx  = 5'(i_place.pin_offset) + 5'(i_place.timers) + 5'(i_place.counters);
  wire [7:0] tx_mask = (tx_idx < 5'h08) ? (8'h01 << tx_idx[2:0]) : 8'h00;
  wire [6:0] rd_len  = (fill_cap_r > 7'h20) ? 7'h20 : fill_cap_r;

  // Shadow state; the placement age saturates so pin checks wait out latency.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_busy_r <= 1'b0;
      rd_on_r   <= 1'b0;
      pl_age_r  <= 2'h0;
    end else begin
      // A request in the reply or done cycle is taken by the design, so it sets the shadow again.
      tx_busy_r <= (tx_busy_r && !o_tx_reply_valid) || i_transmit_request;
      rd_on_r   <= (rd_on_r && !o_rx_done) || i_receive_request;
      pl_age_r  <= (i_place != place_q_r) ? 2'h0 : (pl_age_r + {1'b0, pl_age_r != 2'h3});
    end
    place_q_r  <= i_place;
    dv_cnt_r   <= o_rx_reply_valid ? 7'h00 : (dv_cnt_r + {6'h00, o_rx_data_valid});
    fill_cap_r <= o_rx_reply_valid ? o_rx_fill : fill_cap_r;
  end

  // A read answers, then streams bytes or ends straight away.
  sequence s_rd_first;
    o_rx_reply_valid ##1 (o_rx_data_valid || o_rx_done);
  endsequence

  AST_PIN_PLACE: assert property (pl_age_r == 2'h3 |-> o_fdl_oe_n == ~tx_mask)
    else $error("tx pin placement wrong");
  AST_SPARE_HIGH: assert property (pl_age_r == 2'h3 |-> &(o_fdl_out | tx_mask))
    else $error("undriven lines not high");
  AST_TX_START: assert property (i_transmit_request && !tx_busy_r && i_tx_count inside {[6'h01:6'h38]}
    |=> o_tx_ready && !o_tx_reply_valid) else $error("transmit did not ask for bytes");
  AST_TX_BOUND: assert property (i_transmit_request && !tx_busy_r && (i_tx_count == 6'h00 || i_tx_count > 6'h38)
    |=> o_tx_reply_valid && !o_tx_ready) else $error("empty or oversize transmit not answered");
  AST_RX_OPEN: assert property (i_receive_request && !rd_on_r |=> s_rd_first)
    else $error("read not answered in time");
  AST_RX_BURST: assert property (o_rx_data_valid |=> o_rx_data_valid || o_rx_done)
    else $error("read stream broken");
  AST_RX_LIMIT: assert property (o_rx_done |-> dv_cnt_r == rd_len)
    else $error("read length wrong");
  AST_FILL_HOLD: assert property (rd_on_r && !o_rx_reply_valid && !o_rx_done |-> $stable(o_rx_fill))
    else $error("fill moved during read");
  AST_ENABLE_LOAD: assert property (i_rx_buffering_enable |=> o_rx_enabled == $past(i_enable_value))
    else $error("enable state not loaded");
  AST_DISCARD: assert property (i_rx_buffer_discard && !rd_on_r |-> ##2 o_rx_fill <= 7'h01)
    else $error("discard left bytes");
endmodule : hbu_top_props

bind hbu_top hbu_top_props hbu_top_props_inst (.i_clk, .i_rst, .i_place, .i_rx_buffering_enable,
  .i_enable_value, .i_rx_buffer_discard, .i_transmit_request, .i_tx_count, .o_tx_ready,
  .o_tx_reply_valid, .i_receive_request, .o_rx_reply_valid, .o_rx_data_valid, .o_rx_done,
  .o_rx_fill, .o_rx_enabled, .o_fdl_out, .o_fdl_oe_n);

// ### dv/hbu_serial_partner.sv
// Model of the external serial device on the transmit and receive lines.
// Assumes the design is set to a bit time of BIT_NS in both directions.
`timescale 1ns/100ps
module hbu_serial_partner #(
  parameter real BIT_NS = 333.333
) (
  // Line from the device transmit pin.
  input  wire logic i_line,
  // Line into the device receive pin.
  output logic      o_line
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  int         bad_stop;

  // The line idles high between characters.
  initial begin
    o_line   = 1'b1;
    bad_stop = 0;
  end

  // Sends one character, least significant bit first, with a short idle gap after.
  task automatic send_byte(input logic [7:0] b);
    o_line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      o_line = b[i];
      #(BIT_NS);
    end
    o_line = 1'b1;
    #(BIT_NS * 2.0);
  endtask : send_byte

  // Samples mid-bit; a low stop bit is counted as a framing fault, not stored.
  always begin
    @(negedge i_line);
    #(BIT_NS * 1.5);
    for (int i = 0; i < 8; i++) begin
      sh[i] = i_line;
      #(BIT_NS);
    end
    if (i_line)
      got_q.push_back(sh);
    else
      bad_stop++;
  end
endmodule : hbu_serial_partner

// ### dv/hbu_top_tb.sv
// Self-checking bench for the buffered serial port.
// Assumes the partner model on line four (transmit) and line five (receive).
`timescale 1ns/100ps
module hbu_top_tb;
  logic                i_clk, i_rst, i_rx_buffering_enable, i_enable_value, i_rx_buffer_discard;
  logic                i_transmit_request, i_tx_valid, i_receive_request;
  logic [5:0]          i_tx_count;
  logic [7:0]          i_tx_data, o_rx_data, o_fdl_out, o_fdl_oe_n;
  logic [6:0]          o_rx_fill;
  logic                o_tx_ready, o_tx_reply_valid, o_rx_reply_valid, o_rx_data_valid, o_rx_done;
  logic                o_rx_enabled;
  hbu_pkg::hbu_rate_s  i_rate;
  hbu_pkg::hbu_place_s i_place;
  wire                 rx_line;
  wire  [7:0]          i_fdl_in = {2'b11, rx_line, 5'h1F};
  wire                 tx_line  = o_fdl_oe_n[4] ? 1'b1 : o_fdl_out[4];
  int                  mismatches, total_checks;
  logic [7:0]          exp_q[$];

  hbu_top hbu_top_inst (.i_clk, .i_rst, .i_rate, .i_place, .i_rx_buffering_enable, .i_enable_value,
    .i_rx_buffer_discard, .i_transmit_request, .i_tx_count, .i_tx_data, .i_tx_valid, .o_tx_ready,
    .o_tx_reply_valid, .i_receive_request, .o_rx_reply_valid, .o_rx_data, .o_rx_data_valid,
    .o_rx_done, .o_rx_fill, .o_rx_enabled, .i_fdl_in, .o_fdl_out, .o_fdl_oe_n);
  hbu_serial_partner hbu_serial_partner_inst (.i_line(tx_line), .o_line(rx_line));

  // A 200 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Inputs driven after a tick change one nanosecond after the rising edge.
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Bounded wait for byte request (sel 0) or transmit reply (sel 1).
  task automatic wait_for(input int sel);
    for (int n = 0; n <= 20000; n++) begin
      if (sel == 0 ? o_tx_ready === 1'b1 : o_tx_reply_valid === 1'b1)
        return;
      tick();
    end
    mismatches++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    report_and_stop();
  endtask : wait_for

  // Commands are one-cycle pulses; en picks enable, otherwise discard.
  task automatic command(input logic en, input logic v);
    i_enable_value = v;
    if (en)
      i_rx_buffering_enable = 1'b1;
    else
      i_rx_buffer_discard = 1'b1;
    tick();
    i_rx_buffering_enable = 1'b0;
    i_rx_buffer_discard   = 1'b0;
    repeat (3) tick();
  endtask : command

  // The partner sends n counting bytes; kept ones are expected back on a read.
  task automatic feed(input logic [7:0] b0, input int n, input logic keep);
    for (int i = 0; i < n; i++) begin
      hbu_serial_partner_inst.send_byte(b0 + 8'(i));
      if (keep)
        exp_q.push_back(b0 + 8'(i));
    end
  endtask : feed

  // Transmit request; each byte offered for one cycle once ready is seen, then reply and line contents checked.
  task automatic send_tx(input logic [5:0] cnt, input logic [7:0] b0, input logic [6:0] fill);
    int n;
    n = (cnt > 6'h38) ? 0 : int'(cnt);
    i_transmit_request = 1'b1;
    i_tx_count         = cnt;
    tick();
    i_transmit_request = 1'b0;
    for (int i = 0; i < n; i++) begin
      wait_for(0);
      i_tx_data  = b0 + 8'(i);
      i_tx_valid = 1'b1;
      tick();
      i_tx_valid = 1'b0;
    end
    wait_for(1);
    chk({1'b0, o_rx_fill}, {1'b0, fill}, "tx reply fill");
    tick();
    chk(8'(hbu_serial_partner_inst.got_q.size()), 8'(n), "bytes on line");
    for (int i = 0; i < n; i++)
      chk(hbu_serial_partner_inst.got_q.pop_front(), b0 + 8'(i), "line byte");
  endtask : send_tx

  // Receive request: reply with pre-read fill, at most 32 bytes oldest first, then done.
  task automatic read_rx(input logic [6:0] fill);
    int n;
    n = (fill > 7'h20) ? 32 : int'(fill);
    i_receive_request = 1'b1;
    tick();
    i_receive_request = 1'b0;
    chk({7'h00, o_rx_reply_valid}, 8'h01, "read reply");
    chk({1'b0, o_rx_fill}, {1'b0, fill}, "pre-read fill");
    for (int i = 0; i < n; i++) begin
      tick();
      chk({7'h00, o_rx_data_valid}, 8'h01, "byte strobe");
      chk(o_rx_data, exp_q.pop_front(), "byte value");
    end
    tick();
    chk({7'h00, o_rx_done}, 8'h01, "read done");
    tick();
  endtask : read_rx

  initial begin
    {i_rst, i_rx_buffering_enable, i_enable_value, i_rx_buffer_discard} = 4'h8;
    {i_transmit_request, i_tx_valid, i_receive_request, i_tx_count, i_tx_data} = 17'h00000;
    i_rate  = '{1'b0, 16'hFFF8};
    i_place = '{4'h4, 2'h0, 2'h0};
    mismatches   = 0;
    total_checks = 0;
    repeat (5) tick();
    i_rst = 1'b0;
    repeat (2) tick();
    chk(o_fdl_oe_n, 8'hEF, "tx pin driven");
    chk(o_fdl_out, 8'hFF, "idle levels");
    i_place = '{4'h0, 2'h1, 2'h1};
    repeat (3) tick();
    chk(o_fdl_oe_n, 8'hFB, "pin after timers");
    i_place = '{4'h4, 2'h0, 2'h0};
    repeat (3) tick();
    feed(8'h11, 1, 1'b0);
    chk({1'b0, o_rx_fill}, 8'h00, "no store before enable");
    command(1'b1, 1'b1);
    chk({7'h00, o_rx_enabled}, 8'h01, "enabled");
    feed(8'hC0, 2, 1'b1);
    send_tx(6'h03, 8'hA5, 7'h02);
    read_rx(7'h02);
    feed(8'h20, 34, 1'b1);
    read_rx(7'h22);
    read_rx(7'h02);
    send_tx(6'h00, 8'h00, 7'h00);
    send_tx(6'h39, 8'h00, 7'h00);
    feed(8'h70, 3, 1'b0);
    command(1'b0, 1'b0);
    chk({1'b0, o_rx_fill}, 8'h00, "fill after discard");
    chk({7'h00, o_rx_enabled}, 8'h01, "discard keeps enable");
    read_rx(7'h00);
    i_rate = '{1'b1, 16'h00F0};
    repeat (3) tick();
    send_tx(6'h01, 8'h5A, 7'h00);
    feed(8'h3C, 1, 1'b1);
    read_rx(7'h01);
    command(1'b1, 1'b0);
    feed(8'h44, 1, 1'b0);
    chk({1'b0, o_rx_fill}, 8'h00, "no store when disabled");
    chk(8'(hbu_serial_partner_inst.bad_stop), 8'h00, "stop bits");
    report_and_stop();
  end
endmodule : hbu_top_tb
